// ### pkg/tmco_pkg.sv
// Purpose: Shared constants and types for the contact test-mode override block.
// Assumes: Classic Wishbone register access, 32-bit data, byte addresses.
// Notes:   Register offsets are byte addresses of aligned words.
package tmco_pkg;
   // Register offsets.
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_IN_OVR = 8'h08;
   localparam logic [7:0] OFS_OUT_OVR = 8'h0C;
   localparam logic [7:0] OFS_IN_STATE = 8'h10;
   localparam logic [7:0] OFS_OUT_STATE = 8'h14;
   localparam logic [7:0] OFS_OUT_CMD = 8'h18;
   // Control and status field positions.
   localparam int CTRL_ENABLE_BIT    = 0;
   localparam int CTRL_TRIG_SW_BIT   = 1;
   localparam int CTRL_TRIG_SEL_BIT  = 2;
   localparam int STAT_SESSION_BIT   = 0;
   localparam int STAT_IN_FORCE_BIT  = 1;
   // Values after reset and for unmapped reads.
   localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   // Override selections, two bits per channel.
   typedef enum logic [1:0] {
      IN_FOLLOW = 2'h0,
      IN_OPEN   = 2'h1,
      IN_CLOSED = 2'h2
   } tmco_in_sel_t;
   typedef enum logic [1:0] {
      OUT_FOLLOW = 2'h0,
      OUT_ENERGIZE = 2'h1,
      OUT_DEENERGIZE = 2'h2,
      OUT_FREEZE = 2'h3
   } tmco_out_sel_t;
   // Session states, Gray coded along the entry path from IDLE to ACTIVE.
   typedef enum logic [1:0] {
      SES_IDLE  = 2'b00,
      SES_ENTER = 2'b01,
      SES_ACTIVE = 2'b11
   } tmco_ses_t;
endpackage

// ### hdl/tmco_sync.sv
// Purpose: Two-flop synchroniser for a vector of field-side levels.
// Assumes: Inputs are asynchronous contact levels.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/10ps
module tmco_sync #(
   parameter int W = 8
) (
   // Clock and reset.
   input  wire logic         mclk,
   input  wire logic         rst,
   // Data.
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } tmco_sync_t;
   tmco_sync_t st_r;
   tmco_sync_t st_nxt;
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = din;
      st_nxt.s2 = st_r.s1;
   end
   always_ff @(posedge mclk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign dout = st_r.s2;
endmodule

// ### hdl/tmco_mux.sv
// Purpose: Per-channel override selection for inputs and outputs.
// Assumes: Selections are two-bit codes; active marks a live test session.
// Notes:   Purely combinational; the top registers the results.
`timescale 1ns/10ps
module tmco_mux #(
   parameter int NIN  = 8,
   parameter int NOUT = 8
) (
   // Session.
   input  wire logic              active,
   // Inputs.
   input  wire logic [NIN-1:0]    in_term,
   input  wire logic [2*NIN-1:0]  in_sel,
   output logic      [NIN-1:0]    in_rep,
   // Outputs.
   input  wire logic [NOUT-1:0]   out_ctl,
   input  wire logic [NOUT-1:0]   out_frz,
   input  wire logic [2*NOUT-1:0] out_sel,
   output logic      [NOUT-1:0]   out_drv
);
   always_comb begin
      for (int i = 0; i < NIN; i++) begin
         in_rep[i] = in_term[i];
         if (active) begin
            case (in_sel[2*i +: 2])
               tmco_pkg::IN_OPEN:   in_rep[i] = 1'b0;
               tmco_pkg::IN_CLOSED: in_rep[i] = 1'b1;
               default:             in_rep[i] = in_term[i];
            endcase
         end
      end
      for (int j = 0; j < NOUT; j++) begin
         out_drv[j] = out_ctl[j];
         if (active) begin
            case (out_sel[2*j +: 2])
               tmco_pkg::OUT_ENERGIZE:   out_drv[j] = 1'b1;
               tmco_pkg::OUT_DEENERGIZE: out_drv[j] = 1'b0;
               tmco_pkg::OUT_FREEZE:     out_drv[j] = out_frz[j];
               default:                  out_drv[j] = out_ctl[j];
            endcase
         end
      end
   end
endmodule

// ### hdl/tmco_top.sv
// Purpose: Contact input and output override logic for the test session.
// Assumes: Classic Wishbone slave, one clock, synchronous active-high reset.
// Notes:   Contact terminals are synchronised before use.
// Behaviour
// - Session runs only while enable is set and the trigger is 1.
// - Each input and output channel has its own override selection.
// - Input selection disabled: report the synchronised terminal level.
// - Input selection open: report 0 throughout the session.
// - Input selection closed: report 1 throughout the session.
// - Indicator is on while input overrides hold the session.
// - All input selections disabled returns every input to terminal reporting.
// - Output selection disabled: output follows its control operand.
// - Output selection energize: output closed throughout the session.
// - Output selection de-energize: output open throughout the session.
// - Output selection freeze: hold state captured at session entry.
// - Status reports each channel as 1 for on and 0 for off.
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/10ps
module tmco_top #(
   parameter int NIN  = 8,
   parameter int NOUT = 8
) (
   // Clock and reset.
   input  wire logic              mclk,
   input  wire logic              rst,
   // Wishbone slave.
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // Field side.
   input  wire logic [NIN-1:0]    contact_input_channel,
   output logic      [NOUT-1:0]   contact_output_channel,
   // Logic side.
   input  wire logic              test_trigger,
   input  wire logic [NOUT-1:0]   out_operand,
   output logic      [NIN-1:0]    in_report,
   output logic                   test_led
);
   typedef struct packed {
      logic [31:0]        dat;
      logic               ack;
      logic [2:0]         ctrl;
      logic [2*NIN-1:0]   in_ovr;
      logic [2*NOUT-1:0]  out_ovr;
      logic [NOUT-1:0]    sw_cmd;
      logic [NOUT-1:0]    frz;
      tmco_pkg::tmco_ses_t ses;
      logic [NIN-1:0]     in_rep;
      logic [NOUT-1:0]    out_drv;
      logic               led;
   } tmco_st_t;

   tmco_st_t         st_r;
   tmco_st_t         st_nxt;
   logic [NIN-1:0]   in_sync;
   logic [NIN-1:0]   in_mux;
   logic [NOUT-1:0]  out_mux;
   logic [NOUT-1:0]  ctl_mix;
   logic             trig_sync;
   logic             trig_lvl;
   logic             active;
   logic             any_in_ovr;
   logic             wr_go;
   logic             rd_go;
   logic             ses_req;
   logic             wb_take;

   // Terminal levels and the trigger come from outside the clock domain.
   tmco_sync #(.W(NIN)) u_in_sync (
      .mclk (mclk),
      .rst  (rst),
      .din  (contact_input_channel),
      .dout (in_sync)
   );
   tmco_sync #(.W(1)) u_trig_sync (
      .mclk (mclk),
      .rst  (rst),
      .din  (test_trigger),
      .dout (trig_sync)
   );

   // Merge a 32-bit write into a register, honouring byte selects.
   function automatic logic [31:0] wb_merge(input logic [31:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = dat[8*b +: 8];
         end
      end
      return res;
   endfunction

   // Trigger is either the software bit or the external operand.
   assign trig_lvl = st_r.ctrl[tmco_pkg::CTRL_TRIG_SEL_BIT] ? trig_sync
                     : st_r.ctrl[tmco_pkg::CTRL_TRIG_SW_BIT];
   // Overrides act only once the entry snapshot has been taken.
   assign active = (st_r.ses == tmco_pkg::SES_ACTIVE);
   assign any_in_ovr = |st_r.in_ovr;
   // Output operands may come from pins or from a software command word.
   assign ctl_mix = out_operand | st_r.sw_cmd;
   assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ~st_r.ack;
   assign rd_go = wb_cyc_i & wb_stb_i & ~wb_we_i & ~st_r.ack;
   assign ses_req = st_r.ctrl[tmco_pkg::CTRL_ENABLE_BIT] & trig_lvl;
   assign wb_take = wb_cyc_i & wb_stb_i & ~st_r.ack;

   tmco_mux #(.NIN(NIN), .NOUT(NOUT)) u_mux (
      .active  (active),
      .in_term (in_sync),
      .in_sel  (st_r.in_ovr),
      .in_rep  (in_mux),
      .out_ctl (ctl_mix),
      .out_frz (st_r.frz),
      .out_sel (st_r.out_ovr),
      .out_drv (out_mux)
   );

   always_comb begin
      logic [31:0] rd;
      rd = tmco_pkg::UNMAPPED_READ;
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      // Session sequencing; ENTER takes the freeze snapshot one cycle ahead.
      case (st_r.ses)
         tmco_pkg::SES_IDLE: begin
            if (st_r.ctrl[tmco_pkg::CTRL_ENABLE_BIT] && trig_lvl) begin
               st_nxt.ses = tmco_pkg::SES_ENTER;
               st_nxt.frz = st_r.out_drv;
            end
         end
         tmco_pkg::SES_ENTER: begin
            st_nxt.ses = (st_r.ctrl[tmco_pkg::CTRL_ENABLE_BIT] && trig_lvl)
                         ? tmco_pkg::SES_ACTIVE : tmco_pkg::SES_IDLE;
         end
         tmco_pkg::SES_ACTIVE: begin
            if (!(st_r.ctrl[tmco_pkg::CTRL_ENABLE_BIT] && trig_lvl)) begin
               st_nxt.ses = tmco_pkg::SES_IDLE;
            end
         end
         default: st_nxt.ses = tmco_pkg::SES_IDLE;
      endcase
      st_nxt.in_rep = in_mux;
      st_nxt.out_drv = out_mux;
      st_nxt.led = active & any_in_ovr;
      // Register reads; state reads give 1 for on and 0 for off.
      case (wb_adr_i)
         tmco_pkg::OFS_CTRL:      rd = 32'(st_r.ctrl);
         tmco_pkg::OFS_STATUS:    rd = 32'({any_in_ovr, active});
         tmco_pkg::OFS_IN_OVR:    rd = 32'(st_r.in_ovr);
         tmco_pkg::OFS_OUT_OVR:   rd = 32'(st_r.out_ovr);
         tmco_pkg::OFS_IN_STATE:  rd = 32'(st_r.in_rep);
         tmco_pkg::OFS_OUT_STATE: rd = 32'(st_r.out_drv);
         tmco_pkg::OFS_OUT_CMD:   rd = 32'(st_r.sw_cmd);
         default:                 rd = tmco_pkg::UNMAPPED_READ;
      endcase
      if (wr_go || rd_go) begin
         st_nxt.ack = 1'b1;
      end
      if (rd_go) begin
         st_nxt.dat = rd;
      end
      if (wr_go) begin
         case (wb_adr_i)
            tmco_pkg::OFS_CTRL:
               st_nxt.ctrl = 3'(wb_merge(32'(st_r.ctrl), wb_dat_i, wb_sel_i));
            tmco_pkg::OFS_IN_OVR:
               st_nxt.in_ovr = (2*NIN)'(wb_merge(32'(st_r.in_ovr), wb_dat_i, wb_sel_i));
            tmco_pkg::OFS_OUT_OVR:
               st_nxt.out_ovr = (2*NOUT)'(wb_merge(32'(st_r.out_ovr), wb_dat_i, wb_sel_i));
            tmco_pkg::OFS_OUT_CMD:
               st_nxt.sw_cmd = NOUT'(wb_merge(32'(st_r.sw_cmd), wb_dat_i, wb_sel_i));
            default: st_nxt.ctrl = st_r.ctrl;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign wb_dat_o = st_r.dat;
   assign wb_ack_o = st_r.ack;
   assign contact_output_channel = st_r.out_drv;
   assign in_report = st_r.in_rep;
   assign test_led = st_r.led;

   // Outside the session every output follows its operand, one cycle late.
   chk_idle_out_follow: assert property (@(posedge mclk) disable iff (rst)
      $past(!active) |-> contact_output_channel == $past(ctl_mix))
      else $error("Output did not follow operand outside session.");
   chk_idle_in_follow: assert property (@(posedge mclk) disable iff (rst)
      $past(!active) |-> in_report == $past(in_sync))
      else $error("Input was overridden outside session.");
   chk_ses_needs_en: assert property (@(posedge mclk) disable iff (rst)
      active |-> $past(st_r.ctrl[tmco_pkg::CTRL_ENABLE_BIT] && trig_lvl))
      else $error("Session active without enable and trigger.");
   chk_ses_entry_two: assert property (@(posedge mclk) disable iff (rst)
      (st_r.ses == tmco_pkg::SES_IDLE) && st_r.ctrl[tmco_pkg::CTRL_ENABLE_BIT] && trig_lvl
      ##1 (st_r.ctrl[tmco_pkg::CTRL_ENABLE_BIT] && trig_lvl) |=> active)
      else $error("Session did not start two cycles after request.");
   chk_led_on: assert property (@(posedge mclk) disable iff (rst)
      $past(active && any_in_ovr) |-> test_led)
      else $error("Indicator off during forced-input session.");
   chk_led_off_norm: assert property (@(posedge mclk) disable iff (rst)
      $past(!any_in_ovr) |-> !test_led && in_report == $past(in_sync))
      else $error("Inputs not normal with all selections disabled.");
   chk_force_in0: assert property (@(posedge mclk) disable iff (rst)
      $past(active && st_r.in_ovr[1:0] == 2'h1) |-> !in_report[0])
      else $error("Forced open input did not read zero.");
   chk_force_in1: assert property (@(posedge mclk) disable iff (rst)
      $past(active && st_r.in_ovr[1:0] == 2'h2) |-> in_report[0])
      else $error("Forced closed input did not read one.");
   chk_energize: assert property (@(posedge mclk) disable iff (rst)
      $past(active && st_r.out_ovr[1:0] == 2'h1) |-> contact_output_channel[0])
      else $error("Energized output not closed.");
   chk_deenergize: assert property (@(posedge mclk) disable iff (rst)
      $past(active && st_r.out_ovr[1:0] == 2'h2) |-> !contact_output_channel[0])
      else $error("De-energized output not open.");
   chk_freeze_hold: assert property (@(posedge mclk) disable iff (rst)
      $past(active && st_r.out_ovr[1:0] == 2'h3) |-> contact_output_channel[0] == st_r.frz[0])
      else $error("Frozen output moved during session.");
   chk_ack_pulse: assert property (@(posedge mclk) disable iff (rst)
      wb_ack_o |=> !wb_ack_o)
      else $error("Acknowledge held longer than one cycle.");

   // Bus answers come one cycle after the request, with data of the request cycle.
   chk_ack_answer: assert property (@(posedge mclk) disable iff (rst)
      wb_take |=> wb_ack_o)
      else $error("Request not acknowledged in the next cycle.");
   chk_dat_holds: assert property (@(posedge mclk) disable iff (rst)
      !(wb_take && !wb_we_i) |=> $stable(wb_dat_o))
      else $error("Read data moved without a read.");
   chk_rd_ctrl: assert property (@(posedge mclk) disable iff (rst)
      wb_take && !wb_we_i && wb_adr_i == tmco_pkg::OFS_CTRL
      |=> wb_dat_o == 32'($past(st_r.ctrl)))
      else $error("Control read-back differs from the register.");
   chk_rd_status: assert property (@(posedge mclk) disable iff (rst)
      wb_take && !wb_we_i && wb_adr_i == tmco_pkg::OFS_STATUS
      |=> wb_dat_o == 32'({$past(any_in_ovr), $past(active)}))
      else $error("Status read-back differs from the session state.");
   chk_rd_in_state: assert property (@(posedge mclk) disable iff (rst)
      wb_take && !wb_we_i && wb_adr_i == tmco_pkg::OFS_IN_STATE
      |=> wb_dat_o == 32'($past(in_report)))
      else $error("Input state read-back differs from the report.");
   chk_rd_out_state: assert property (@(posedge mclk) disable iff (rst)
      wb_take && !wb_we_i && wb_adr_i == tmco_pkg::OFS_OUT_STATE
      |=> wb_dat_o == 32'($past(contact_output_channel)))
      else $error("Output state read-back differs from the drive.");
   chk_rd_unmapped: assert property (@(posedge mclk) disable iff (rst)
      wb_take && !wb_we_i && wb_adr_i > tmco_pkg::OFS_OUT_CMD
      |=> wb_dat_o == tmco_pkg::UNMAPPED_READ)
      else $error("Unmapped read returned data.");

   // Writes land one cycle after the request; unmapped writes leave every setting alone.
   chk_wr_ctrl: assert property (@(posedge mclk) disable iff (rst)
      wb_take && wb_we_i && wb_adr_i == tmco_pkg::OFS_CTRL && wb_sel_i[0]
      |=> st_r.ctrl == $past(wb_dat_i[2:0]))
      else $error("Control write did not land.");
   chk_wr_in_ovr: assert property (@(posedge mclk) disable iff (rst)
      wb_take && wb_we_i && wb_adr_i == tmco_pkg::OFS_IN_OVR && wb_sel_i == 4'hF
      |=> st_r.in_ovr == $past(wb_dat_i[2*NIN-1:0]))
      else $error("Input selection write did not land.");
   chk_wr_out_ovr: assert property (@(posedge mclk) disable iff (rst)
      wb_take && wb_we_i && wb_adr_i == tmco_pkg::OFS_OUT_OVR && wb_sel_i == 4'hF
      |=> st_r.out_ovr == $past(wb_dat_i[2*NOUT-1:0]))
      else $error("Output selection write did not land.");
   chk_wr_cmd: assert property (@(posedge mclk) disable iff (rst)
      wb_take && wb_we_i && wb_adr_i == tmco_pkg::OFS_OUT_CMD && wb_sel_i == 4'hF
      |=> st_r.sw_cmd == $past(wb_dat_i[NOUT-1:0]))
      else $error("Command word write did not land.");
   chk_wr_unmapped: assert property (@(posedge mclk) disable iff (rst)
      wb_take && wb_we_i && wb_adr_i > tmco_pkg::OFS_OUT_CMD
      |=> st_r.ctrl == $past(st_r.ctrl) && st_r.in_ovr == $past(st_r.in_ovr)
          && st_r.out_ovr == $past(st_r.out_ovr) && st_r.sw_cmd == $past(st_r.sw_cmd))
      else $error("Unmapped write changed a setting.");

   // Per-channel selections: disabled and unused codes checked on the first channel, forced codes on the last.
   chk_in_disabled: assert property (@(posedge mclk) disable iff (rst)
      $past(st_r.in_ovr[1:0] == 2'h0) |-> in_report[0] == $past(in_sync[0]))
      else $error("Disabled input did not follow its terminal.");
   chk_in_code_three: assert property (@(posedge mclk) disable iff (rst)
      $past(st_r.in_ovr[1:0] == 2'h3) |-> in_report[0] == $past(in_sync[0]))
      else $error("Unused input code overrode the terminal.");
   chk_out_disabled: assert property (@(posedge mclk) disable iff (rst)
      $past(st_r.out_ovr[1:0] == 2'h0) |-> contact_output_channel[0] == $past(ctl_mix[0]))
      else $error("Disabled output did not follow its operand.");
   chk_open_last: assert property (@(posedge mclk) disable iff (rst)
      $past(active && st_r.in_ovr[2*NIN-1 -: 2] == 2'h1) |-> !in_report[NIN-1])
      else $error("Forced open last input did not read zero.");
   chk_closed_last: assert property (@(posedge mclk) disable iff (rst)
      $past(active && st_r.in_ovr[2*NIN-1 -: 2] == 2'h2) |-> in_report[NIN-1])
      else $error("Forced closed last input did not read one.");
   chk_energize_last: assert property (@(posedge mclk) disable iff (rst)
      $past(active && st_r.out_ovr[2*NOUT-1 -: 2] == 2'h1) |-> contact_output_channel[NOUT-1])
      else $error("Energized last output not closed.");
   chk_deenergize_last: assert property (@(posedge mclk) disable iff (rst)
      $past(active && st_r.out_ovr[2*NOUT-1 -: 2] == 2'h2) |-> !contact_output_channel[NOUT-1])
      else $error("De-energized last output not open.");
   chk_freeze_last: assert property (@(posedge mclk) disable iff (rst)
      $past(active && st_r.out_ovr[2*NOUT-1 -: 2] == 2'h3)
      |-> contact_output_channel[NOUT-1] == st_r.frz[NOUT-1])
      else $error("Frozen last output moved during session.");

   // Entry takes the snapshot from the drive that stood before the session.
   chk_freeze_take: assert property (@(posedge mclk) disable iff (rst)
      st_r.ses == tmco_pkg::SES_IDLE && ses_req
      |=> st_r.frz == $past(contact_output_channel))
      else $error("Freeze snapshot not taken at session entry.");
   chk_idle_stays: assert property (@(posedge mclk) disable iff (rst)
      st_r.ses == tmco_pkg::SES_IDLE && !ses_req |=> !active)
      else $error("Session started without a request.");
   chk_ses_exit: assert property (@(posedge mclk) disable iff (rst)
      active && !ses_req |=> !active)
      else $error("Session outlived its enable or trigger.");
   chk_led_needs_ses: assert property (@(posedge mclk) disable iff (rst)
      test_led |-> $past(active))
      else $error("Indicator on outside a session.");

   cov_session: cover property (@(posedge mclk) disable iff (rst) !active ##1 active);
   cov_pin_trigger: cover property (@(posedge mclk) disable iff (rst)
      active && st_r.ctrl[tmco_pkg::CTRL_TRIG_SEL_BIT]);
   cov_freeze: cover property (@(posedge mclk) disable iff (rst)
      active && st_r.out_ovr[1:0] == 2'h3 && ctl_mix[0] != st_r.frz[0]);
   cov_forced_in: cover property (@(posedge mclk) disable iff (rst) test_led);
   cov_exit: cover property (@(posedge mclk) disable iff (rst) active ##1 !active);
endmodule

// ### bench/tmco_field.sv
// Purpose: Field-side model of the contact wiring and relay coils.
// Assumes: Terminal voltages change just after a clock edge, like any asynchronous source.
// Notes:   The relay state seen by the field lags the drive by one cycle, as a real coil would.
`timescale 1ns/10ps
module tmco_field (
   // Clock.
   input  wire logic       mclk,
   // Terminal voltages that the bench asks for.
   input  wire logic [7:0] level_req,
   output logic      [7:0] terminal,
   // Relay drive from the device and what the field sees of it.
   input  wire logic [7:0] relay_drive,
   output logic      [7:0] relay_seen
);
   always @(posedge mclk) begin
      terminal   <= level_req;
      relay_seen <= relay_drive;
   end
endmodule

// ### bench/tb.sv
// Purpose: Self-checking bench for the contact test-mode override block.
// Assumes: Classic Wishbone register access; one 40 MHz clock.
// Notes:   Expected values come from a behavioural model kept in this file.
`timescale 1ns/10ps
module tb;
   logic        mclk = 1'b0;
   logic        rst  = 1'b1;
   logic        cyc  = 1'b0;
   logic        stb  = 1'b0;
   logic        we   = 1'b0;
   logic [7:0]  adr  = 8'h00;
   logic [31:0] dat  = 32'h0000_0000;
   logic [31:0] rdat;
   logic        ack;
   logic [7:0]  term_req = 8'h00;
   logic [7:0]  op       = 8'h00;
   logic        trig     = 1'b0;
   logic [7:0]  pins;
   logic [7:0]  drive;
   logic [7:0]  relay;
   logic [7:0]  in_rep;
   logic        led;
   int          fail_count = 0;
   int          num_checks = 0;

   always #12.5 mclk = ~mclk;

   tmco_top u_tmco_top (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .contact_input_channel(pins), .contact_output_channel(drive),
      .test_trigger(trig), .out_operand(op), .in_report(in_rep), .test_led(led));
   tmco_field u_tmco_field (.mclk(mclk), .level_req(term_req), .terminal(pins),
      .relay_drive(drive), .relay_seen(relay));

   function automatic logic [7:0] exp_in(input logic [7:0] t, input logic [15:0] s);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         case (s[2*i+:2])
            2'h1: r[i] = 1'b0;
            2'h2: r[i] = 1'b1;
            default: r[i] = t[i];
         endcase
      end
      return r;
   endfunction

   function automatic logic [7:0] exp_out(input logic [7:0] o, f, input logic [15:0] s);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) begin
         case (s[2*i+:2])
            2'h0: r[i] = o[i];
            2'h1: r[i] = 1'b1;
            2'h2: r[i] = 1'b0;
            default: r[i] = f[i];
         endcase
      end
      return r;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // The request stands until ack is sampled high; no fixed latency is assumed.
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
      int n = 0;
      @(posedge mclk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge mclk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = rdat;
      if (n >= 40) fail_count++;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      wb(1'b0, a, 32'h0000_0000, q);
   endtask

   // Eight cycles cover the four-edge input path from term_req and the session entry walk.
   task automatic settle;
      repeat (8) @(posedge mclk);
   endtask

   task complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      #(25 * 20000);
      fail_count++;
      complete_run;
   end

   initial begin
      logic [31:0] q;
      logic [15:0] isel;
      logic [15:0] osel;
      logic [7:0]  cmd;
      logic [7:0]  frz;
      void'($urandom(32'h5E4EA6F6));
      term_req <= 8'($urandom);
      repeat (12) @(posedge mclk);
      chk({24'h0, in_rep}, 32'h0);
      chk({24'h0, drive}, 32'h0);
      rst <= 1'b0;
      rd(tmco_pkg::OFS_CTRL, q);
      chk(q, tmco_pkg::RST_ZERO);
      rd(tmco_pkg::OFS_STATUS, q);
      chk(q, tmco_pkg::RST_ZERO);
      for (int i = 0; i < 8; i++) begin
         op       <= 8'($urandom);
         term_req <= 8'($urandom);
         cmd  = 8'($urandom);
         isel = (i == 0) ? 16'h0000 : 16'($urandom);
         osel = 16'($urandom);
         // Enabled but not triggered: no session may start yet.
         wr(tmco_pkg::OFS_CTRL, i[0] ? 32'h1 : 32'h5);
         wr(tmco_pkg::OFS_IN_OVR, {16'h0, isel});
         wr(tmco_pkg::OFS_OUT_OVR, {16'h0, osel});
         wr(tmco_pkg::OFS_OUT_CMD, {24'h0, cmd});
         settle;
         frz = op | cmd;
         chk({24'h0, in_rep}, {24'h0, term_req});
         chk({24'h0, relay}, {24'h0, frz});
         chk({31'h0, led}, 32'h0);
         if (i[0]) begin
            wr(tmco_pkg::OFS_CTRL, 32'h3);
         end else begin
            trig <= 1'b1;
         end
         settle;
         op       <= 8'($urandom);
         term_req <= 8'($urandom);
         settle;
         chk({24'h0, in_rep}, {24'h0, exp_in(term_req, isel)});
         chk({24'h0, relay}, {24'h0, exp_out(op | cmd, frz, osel)});
         chk({31'h0, led}, {31'h0, |isel});
         rd(tmco_pkg::OFS_STATUS, q);
         chk(q, {30'h0, |isel, 1'b1});
         rd(tmco_pkg::OFS_IN_STATE, q);
         chk(q, {24'h0, exp_in(term_req, isel)});
         rd(tmco_pkg::OFS_OUT_STATE, q);
         chk(q, {24'h0, exp_out(op | cmd, frz, osel)});
         wr(tmco_pkg::OFS_CTRL, 32'h0);
         trig <= 1'b0;
         settle;
         chk({24'h0, relay}, {24'h0, op | cmd});
         chk({24'h0, in_rep}, {24'h0, term_req});
      end
      // Unmapped places answer with zero and swallow writes.
      rd(8'h1C, q);
      chk(q, tmco_pkg::UNMAPPED_READ);
      wr(8'h20, 32'hFFFF_FFFF);
      rd(tmco_pkg::OFS_CTRL, q);
      chk(q, tmco_pkg::RST_ZERO);
      complete_run;
   end
endmodule
